/* hdl/rsp_defs.vh */
`ifndef RSP_DEFS_VH
`define RSP_DEFS_VH
// register byte addresses
`define RSP_ADDR_CTRL 8'h00
`define RSP_ADDR_STAT 8'h04
`define RSP_ADDR_TXD 8'h08
`define RSP_ADDR_RXD 8'h0C
// control field positions and reset values
`define RSP_CTRL_BAUD 2:0
`define RSP_CTRL_FMT 4:3
`define RSP_CTRL_FLOW 7:5
`define RSP_CTRL_SER 8
`define RSP_CTRL_KEY 10:9
`define RSP_CTRL_RST 11'h026
// baud selects
`define RSP_BAUD_1200 3'h0
`define RSP_BAUD_2400 3'h1
`define RSP_BAUD_4800 3'h2
`define RSP_BAUD_9600 3'h3
`define RSP_BAUD_19200 3'h4
`define RSP_BAUD_38400 3'h5
`define RSP_BAUD_57600 3'h6
`define RSP_BAUD_115200 3'h7
// frame formats
`define RSP_FMT_8N 2'h0
`define RSP_FMT_7E 2'h1
`define RSP_FMT_7O 2'h2
// flow control modes
`define RSP_FLOW_NONE 3'h0
`define RSP_FLOW_XON 3'h1
`define RSP_FLOW_DTR 3'h2
`define RSP_FLOW_RTS 3'h3
`define RSP_FLOW_MODEM 3'h4
// keypad modes
`define RSP_KEY_LOCAL 2'h0
`define RSP_KEY_REMOTE 2'h1
`define RSP_KEY_LOCKOUT 2'h2
// status bits
`define RSP_ST_CNT 7:0
`define RSP_ST_HALT 8
`define RSP_ST_FERR 9
`define RSP_ST_PERR 10
`define RSP_ST_OVR 11
`define RSP_ST_ABORT 12
`define RSP_ST_BUSY 13
`define RSP_RXD_VALID 8
// control characters
`define RSP_CHAR_XOFF 8'h13
`define RSP_CHAR_XON 8'h11
`define RSP_CHAR_ETX 8'h03
// bit timing
`define RSP_OVERSAMPLE 16
`define RSP_MID_TICK 4'h7
`define RSP_LAST_TICK 4'hF
`define RSP_LAST_BIT 3'h7
`endif

/* hdl/rsp_buf.v */
`default_nettype none
// two-entry buffer; full throughput with registered outputs
module rsp_buf #(
  parameter W = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  input wire flush,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg rd_q;
  reg wr_q;
  reg [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];

  always @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (flush) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule // rsp_buf
`default_nettype wire

/* hdl/rsp_port.v */
// The placing of the registers and the APB register port were chosen for this implementation.
`include "rsp_defs.vh"
`default_nettype none
module rsp_port #(
  parameter CLK_HZ = 100000000,
  parameter RX_AW = 7,
  parameter RX_HIGH = 100
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // serial pins, level high means true
  input wire rxd,
  input wire dsr,
  input wire cts,
  output reg txd,
  output reg dtr,
  output reg rts,
  // instrument side
  output wire serial_selected,
  output wire keys_enabled,
  output wire local_key_enabled,
  output reg abort_pulse
);
  localparam RX_DEPTH = 1 << RX_AW;
  localparam TX_IDLE = 2'b01;
  localparam TX_RUN = 2'b10;
  localparam RX_IDLE = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_BITS = 4'b0100;
  localparam RX_STOP = 4'b1000;

  reg [10:0] ctrl_q;
  wire [2:0] baud_sel = ctrl_q[`RSP_CTRL_BAUD];
  wire [1:0] fmt = ctrl_q[`RSP_CTRL_FMT];
  wire [2:0] flow = ctrl_q[`RSP_CTRL_FLOW];
  wire [1:0] key_mode = ctrl_q[`RSP_CTRL_KEY];
  assign serial_selected = ctrl_q[`RSP_CTRL_SER];
  // keypad gating only applies while the serial port owns the instrument
  assign keys_enabled = !serial_selected || (key_mode == `RSP_KEY_LOCAL);
  assign local_key_enabled = !serial_selected || (key_mode != `RSP_KEY_LOCKOUT);

  // 16x tick divisor per rate
  function [15:0] div_of;
    input [2:0] sel;
    integer rate;
    integer quot;
    begin
      rate = 1200;
      case (sel)
        `RSP_BAUD_1200: rate = 1200;
        `RSP_BAUD_2400: rate = 2400;
        `RSP_BAUD_4800: rate = 4800;
        `RSP_BAUD_9600: rate = 9600;
        `RSP_BAUD_19200: rate = 19200;
        `RSP_BAUD_38400: rate = 38400;
        `RSP_BAUD_57600: rate = 57600;
        `RSP_BAUD_115200: rate = 115200;
        default: rate = 1200;
      endcase
      quot = CLK_HZ / (rate * `RSP_OVERSAMPLE);
      div_of = quot[15:0];
    end
  endfunction

  reg [15:0] div_q;
  wire tick = (div_q == 16'h0000);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else if (tick) begin
      div_q <= div_of(baud_sel) - 16'h0001;
    end else begin
      div_q <= div_q - 16'h0001;
    end
  end

  // pin synchronisers: rxd, dsr, cts; a change is taken when stages 2 and 3 agree
  reg [2:0] s1_q;
  reg [2:0] s2_q;
  reg [2:0] s3_q;
  reg [2:0] pin_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h1;
      s2_q <= 3'h1;
      s3_q <= 3'h1;
      pin_q <= 3'h1;
    end else begin
      s1_q <= {cts, dsr, rxd};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end
  wire rx_pin = pin_q[0];
  wire dsr_in = pin_q[1];
  wire cts_in = pin_q[2];

  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire a_ctrl = (paddr == `RSP_ADDR_CTRL);
  wire a_stat = (paddr == `RSP_ADDR_STAT);
  wire a_txd = (paddr == `RSP_ADDR_TXD);
  wire a_rxd = (paddr == `RSP_ADDR_RXD);
  wire mapped = a_ctrl || a_stat || a_txd || a_rxd;
  wire tx_in_ready;
  // a transmit write stalls the bus until the buffer has room
  assign pready = !(pwrite && a_txd) || tx_in_ready;
  assign pslverr = access && !mapped;
  wire done = access && pready && mapped;
  wire wr_ctrl = done && pwrite && a_ctrl;
  wire wr_stat = done && pwrite && a_stat;
  wire wr_txd = access && pwrite && a_txd;
  wire rd_rxd = done && !pwrite && a_rxd;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RSP_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[10:0];
    end
  end

  // receive fifo
  reg [7:0] rx_mem [0:RX_DEPTH-1];
  reg [RX_AW-1:0] rx_wp_q;
  reg [RX_AW-1:0] rx_rp_q;
  reg [RX_AW:0] rx_cnt_q;
  reg [7:0] rx_byte_d;
  reg rx_store;
  wire rx_empty = (rx_cnt_q == {(RX_AW+1){1'b0}});
  wire rx_full = (rx_cnt_q == RX_DEPTH[RX_AW:0]);
  wire rx_pop = rd_rxd && !rx_empty;
  wire rx_push = rx_store && !rx_full;
  // high-water mark; headroom absorbs characters already in flight
  wire near_full = (rx_cnt_q >= RX_HIGH[RX_AW:0]);
  always @(posedge pclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_byte_d;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_q <= {RX_AW{1'b0}};
      rx_rp_q <= {RX_AW{1'b0}};
      rx_cnt_q <= {(RX_AW+1){1'b0}};
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      if (rx_push && !rx_pop) begin
        rx_cnt_q <= rx_cnt_q + 1'b1;
      end else if (rx_pop && !rx_push) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end
    end
  end

  // receiver
  reg [3:0] rx_st_q;
  reg [3:0] rx_tk_q;
  reg [2:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg rx_done;
  reg rx_ferr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      rx_tk_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
      if (tick) begin
        rx_tk_q <= rx_tk_q + 4'h1;
        case (rx_st_q)
          RX_IDLE: begin
            rx_tk_q <= 4'h0;
            if (!rx_pin && serial_selected) begin
              rx_st_q <= RX_START;
            end
          end
          RX_START: begin
            if (rx_tk_q == `RSP_MID_TICK) begin
              rx_tk_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_st_q <= rx_pin ? RX_IDLE : RX_BITS;
            end
          end
          RX_BITS: begin
            if (rx_tk_q == `RSP_LAST_TICK) begin
              rx_sh_q <= {rx_pin, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == `RSP_LAST_BIT) begin
                rx_st_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_tk_q == `RSP_LAST_TICK) begin
              rx_done <= rx_pin;
              rx_ferr <= !rx_pin;
              rx_st_q <= RX_IDLE;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  // received character handling
  wire seven = (fmt != `RSP_FMT_8N);
  wire perr = seven && ((^rx_sh_q) != (fmt == `RSP_FMT_7O));
  wire [7:0] rx_char = seven ? {1'b0, rx_sh_q[6:0]} : rx_sh_q;
  wire xon_mode = (flow == `RSP_FLOW_XON);
  wire got_abort = rx_done && (rx_char == `RSP_CHAR_ETX);
  wire got_xoff = rx_done && xon_mode && (rx_char == `RSP_CHAR_XOFF);
  wire got_xon = rx_done && xon_mode && (rx_char == `RSP_CHAR_XON);
  always @* begin
    rx_byte_d = rx_char;
    rx_store = rx_done && !got_abort && !got_xoff && !got_xon;
  end

  reg halt_q;
  reg ferr_q;
  reg perr_q;
  reg ovr_q;
  reg abort_q;
  wire [31:0] clr = wr_stat ? pwdata : 32'h0000_0000;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= 1'b0;
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
      ovr_q <= 1'b0;
      abort_q <= 1'b0;
      abort_pulse <= 1'b0;
    end else begin
      abort_pulse <= got_abort;
      if (got_xoff) begin
        halt_q <= 1'b1;
      end else if (got_xon || !xon_mode || got_abort) begin
        halt_q <= 1'b0;
      end
      // a new event in the clearing cycle wins
      ferr_q <= rx_ferr || (ferr_q && !clr[`RSP_ST_FERR]);
      perr_q <= (rx_done && perr) || (perr_q && !clr[`RSP_ST_PERR]);
      ovr_q <= (rx_store && rx_full) || (ovr_q && !clr[`RSP_ST_OVR]);
      abort_q <= got_abort || (abort_q && !clr[`RSP_ST_ABORT]);
    end
  end

  // transmit path
  wire tx_valid;
  wire [7:0] tx_data;
  reg [1:0] tx_st_q;
  reg [3:0] tx_tk_q;
  reg [3:0] tx_bit_q;
  reg [8:0] tx_sh_q;
  reg tx_go;
  always @* begin
    case (flow)
      `RSP_FLOW_XON: tx_go = !halt_q;
      `RSP_FLOW_DTR: tx_go = dsr_in;
      `RSP_FLOW_RTS: tx_go = cts_in;
      `RSP_FLOW_MODEM: tx_go = dsr_in && cts_in;
      default: tx_go = 1'b1;
    endcase
  end
  // flow gating takes effect at character boundaries only
  wire tx_take = (tx_st_q == TX_IDLE) && tick && tx_go && serial_selected;

  rsp_buf #(
    .W(8)
  ) u_txbuf (
    .pclk(pclk),
    .presetn(presetn),
    .flush(got_abort),
    .in_valid(wr_txd),
    .in_ready(tx_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(tx_valid),
    .out_ready(tx_take),
    .out_data(tx_data)
  );

  wire tx_par = (^tx_data[6:0]) ^ (fmt == `RSP_FMT_7O);
  wire [7:0] tx_frame = seven ? {tx_par, tx_data[6:0]} : tx_data;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tx_tk_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1FF;
      txd <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          txd <= 1'b1;
          if (tx_take && tx_valid) begin
            txd <= 1'b0;
            tx_sh_q <= {1'b1, tx_frame};
            tx_tk_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_st_q <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (tick) begin
            tx_tk_q <= tx_tk_q + 4'h1;
            if (tx_tk_q == `RSP_LAST_TICK) begin
              txd <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[8:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == 4'h9) begin
                txd <= 1'b1;
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // handshake outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr <= 1'b0;
      rts <= 1'b0;
    end else if (!serial_selected) begin
      dtr <= 1'b0;
      rts <= 1'b0;
    end else begin
      case (flow)
        `RSP_FLOW_DTR: begin
          dtr <= !near_full;
          rts <= 1'b1;
        end
        `RSP_FLOW_RTS: begin
          dtr <= 1'b1;
          rts <= !near_full;
        end
        `RSP_FLOW_MODEM: begin
          dtr <= 1'b1;
          rts <= !near_full;
        end
        default: begin
          dtr <= 1'b1;
          rts <= 1'b1;
        end
      endcase
    end
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
      if (a_ctrl) begin
        prdata[10:0] <= ctrl_q;
      end else if (a_stat) begin
        prdata[`RSP_ST_CNT] <= rx_cnt_q;
        prdata[`RSP_ST_HALT] <= halt_q;
        prdata[`RSP_ST_FERR] <= ferr_q;
        prdata[`RSP_ST_PERR] <= perr_q;
        prdata[`RSP_ST_OVR] <= ovr_q;
        prdata[`RSP_ST_ABORT] <= abort_q;
        prdata[`RSP_ST_BUSY] <= (tx_st_q != TX_IDLE) || tx_valid;
      end else if (a_rxd) begin
        prdata[7:0] <= rx_empty ? 8'h00 : rx_mem[rx_rp_q];
        prdata[`RSP_RXD_VALID] <= !rx_empty;
      end
    end
  end
endmodule // rsp_port
`default_nettype wire

/* tb/rsp_port_props.sv */
`include "rsp_defs.vh"
`default_nettype none
module rsp_port_props #(
  parameter CLK_HZ = 100000000
) (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // serial pins
  input wire logic dsr,
  input wire logic cts,
  input wire logic txd,
  input wire logic dtr,
  input wire logic rts,
  // instrument side
  input wire logic serial_selected,
  input wire logic keys_enabled,
  input wire logic local_key_enabled,
  input wire logic abort_pulse
);
  // frame timing is only judged at 115200 baud, exact when CLK_HZ divides evenly
  // same rounding as the design's divisor
  localparam int BIT = 16 * (CLK_HZ / (115200 * 16));
  localparam int HB = BIT / 2;
  localparam int NB = 9 * BIT;
  logic [10:0] ctrl_q;
  logic [9:0] fcnt_q;
  logic txd_q;
  logic start;
  logic [2:0] flow;
  logic [1:0] keym;
  assign flow = ctrl_q[`RSP_CTRL_FLOW];
  assign keym = ctrl_q[`RSP_CTRL_KEY];
  // a fall outside a running frame opens a new one
  assign start = txd_q && !txd && fcnt_q == 10'h000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RSP_CTRL_RST;
      fcnt_q <= 10'h000;
      txd_q <= 1'b1;
    end else begin
      txd_q <= txd;
      if (psel && penable && pready && pwrite && paddr == `RSP_ADDR_CTRL) ctrl_q <= pwdata[10:0];
      if (start) fcnt_q <= 10'(10 * BIT - 2);
      else if (fcnt_q != 10'h000) fcnt_q <= fcnt_q - 10'h001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_start;
    start && ctrl_q[`RSP_CTRL_BAUD] == `RSP_BAUD_115200;
  endsequence
  sequence s_frame;
    ##HB !txd ##NB txd;
  endsequence
  property p_frame;
    s_start |-> s_frame;
  endproperty
  a_frame: assert property (p_frame) else $error("bad start or stop bit");
  property p_quiet;
    !serial_selected [*2] |-> txd && !dtr && !rts;
  endproperty
  a_quiet: assert property (p_quiet) else $error("serial pins active while deselected");
  property p_modem_dtr;
    (serial_selected && flow == `RSP_FLOW_MODEM) [*2] |-> dtr;
  endproperty
  a_modem_dtr: assert property (p_modem_dtr) else $error("dtr low in modem mode");
  property p_remote;
    serial_selected && keym == `RSP_KEY_REMOTE |-> !keys_enabled && local_key_enabled;
  endproperty
  a_remote: assert property (p_remote) else $error("remote key gating wrong");
  property p_lockout;
    serial_selected && keym == `RSP_KEY_LOCKOUT |-> !keys_enabled && !local_key_enabled;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout key gating wrong");
  property p_local;
    serial_selected && keym == `RSP_KEY_LOCAL |-> keys_enabled && local_key_enabled;
  endproperty
  a_local: assert property (p_local) else $error("local keys disabled");
  property p_dsr_gate;
    (flow == `RSP_FLOW_DTR && !dsr) [*8] |-> !start;
  endproperty
  a_dsr_gate: assert property (p_dsr_gate) else $error("frame sent without dsr");
  property p_cts_gate;
    (flow == `RSP_FLOW_RTS && !cts) [*8] |-> !start;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("frame sent without cts");
  property p_abort;
    abort_pulse |-> serial_selected ##1 !abort_pulse;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pulse malformed");
endmodule // rsp_port_props
bind rsp_port rsp_port_props #(.CLK_HZ(CLK_HZ)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .dsr(dsr), .cts(cts), .txd(txd), .dtr(dtr), .rts(rts),
  .serial_selected(serial_selected), .keys_enabled(keys_enabled),
  .local_key_enabled(local_key_enabled), .abort_pulse(abort_pulse));
`default_nettype wire

/* tb/rsp_host.sv */
`default_nettype none
module rsp_host #(
  parameter int BIT = 32
) (
  // clock
  input wire logic pclk,
  // serial pins
  input wire logic txd,
  output logic rxd,
  output logic dsr,
  output logic cts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx_q[$];
  logic [8:0] cap;
  initial begin
    rxd = 1'b1;
    dsr = 1'b1;
    cts = 1'b1;
  end
  // modem side: dsr while on-line, cts while accepting
  task automatic set_lines(input logic d, input logic c);
    dsr <= d;
    cts <= c;
  endtask
  // one start, eight bits lsb first, one stop
  task automatic send_char(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (BIT) @(posedge pclk);
    end
  endtask
  // centre sampling; stop level kept above the data
  always @(negedge txd) begin
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge pclk);
      cap[i] = txd;
    end
    rx_q.push_back(cap);
  end
endmodule // rsp_host
`default_nettype wire

/* tb/testbench.sv */
`include "rsp_defs.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  localparam int HIGH = 4;
  logic pclk, presetn, psel, penable, pwrite, er;
  logic [7:0] paddr, c;
  logic [31:0] pwdata, rd;
  logic [2:0] modes[3];
  wire logic pready, pslverr, rxd, dsr, cts, txd, dtr, rts, sel, keys, lkey, abrt;
  wire logic [31:0] prdata;
  int mismatches, check_count, w;
  rsp_port #(.CLK_HZ(3686400), .RX_AW(7), .RX_HIGH(HIGH)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .rxd(rxd), .dsr(dsr), .cts(cts),
    .txd(txd), .dtr(dtr), .rts(rts), .serial_selected(sel), .keys_enabled(keys),
    .local_key_enabled(lkey), .abort_pulse(abrt));
  rsp_host #(.BIT(BIT)) host (.pclk(pclk), .txd(txd), .rxd(rxd), .dsr(dsr), .cts(cts));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic give_verdict;
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic fail;
    mismatches++;
    $display("mismatch at %0t: wait timed out", $time);
    give_verdict();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    rdy = 1'b0;
    // inputs only move at rising edges, so the falling edge shows what the next edge takes
    while (!rdy && w < 400) begin
      @(negedge pclk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      w++;
    end
    if (!rdy) fail();
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic get_tx(input logic [7:0] e);
    int n;
    n = 0;
    while (host.rx_q.size() == 0 && n < 20 * BIT) begin
      @(posedge pclk);
      n++;
    end
    if (host.rx_q.size() == 0) fail();
    check({23'h0, host.rx_q.pop_front()}, {24'h1, e});
  endtask
  task automatic rx_chk(input logic [7:0] s, input logic [7:0] e);
    host.send_char(s);
    repeat (4) @(posedge pclk);
    apb(`RSP_ADDR_RXD, 1'b0, 32'h0);
    check(rd, {23'h0, 1'b1, e});
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] k, input logic [2:0] f,
                                      input logic [1:0] fm);
    return {21'h0, k, 1'b1, f, fm, `RSP_BAUD_115200};
  endfunction
  function automatic logic [7:0] enc(input logic [7:0] d, input logic [1:0] fm);
    if (fm == `RSP_FMT_8N) return d;
    return {(fm == `RSP_FMT_7O) ? ~^d[6:0] : ^d[6:0], d[6:0]};
  endfunction
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    check_count = 0;
    modes = '{`RSP_FLOW_DTR, `RSP_FLOW_RTS, `RSP_FLOW_MODEM};
    void'($urandom(32'hE7337B30));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(`RSP_ADDR_CTRL, 1'b0, 32'h0);
    check(rd, {21'h0, `RSP_KEY_LOCAL, 1'b0, `RSP_FLOW_XON, `RSP_FMT_8N, `RSP_BAUD_57600});
    apb(8'h10, 1'b0, 32'h0);
    check({31'h0, er}, 32'h1);
    host.send_char(8'h41);
    apb(`RSP_ADDR_RXD, 1'b0, 32'h0);
    check({31'h0, rd[8]}, 32'h0);
    for (int k = 0; k < 3; k++) begin
      apb(`RSP_ADDR_CTRL, 1'b1, ctl(2'(k), `RSP_FLOW_NONE, `RSP_FMT_8N));
      check({30'h0, keys, lkey}, (k == 0) ? 32'h3 : (k == 1) ? 32'h1 : 32'h0);
    end
    for (int fm = 0; fm < 3; fm++) begin
      apb(`RSP_ADDR_CTRL, 1'b1, ctl(`RSP_KEY_LOCAL, `RSP_FLOW_NONE, 2'(fm)));
      c = 8'($urandom);
      apb(`RSP_ADDR_TXD, 1'b1, {24'h0, c});
      get_tx(enc(c, 2'(fm)));
      c = 8'($urandom);
      rx_chk(enc(c, 2'(fm)), (fm == 0) ? c : {1'b0, c[6:0]});
    end
    host.set_lines(1'b0, 1'b1);
    apb(`RSP_ADDR_CTRL, 1'b1, ctl(`RSP_KEY_LOCAL, `RSP_FLOW_DTR, `RSP_FMT_8N));
    apb(`RSP_ADDR_TXD, 1'b1, 32'h5A);
    apb(`RSP_ADDR_TXD, 1'b1, 32'hA5);
    fork
      apb(`RSP_ADDR_TXD, 1'b1, 32'h3C);
      begin
        repeat (60) @(posedge pclk);
        host.set_lines(1'b1, 1'b1);
      end
    join
    check({31'h0, w > 55}, 32'h1);
    get_tx(8'h5A);
    get_tx(8'hA5);
    get_tx(8'h3C);
    foreach (modes[m]) begin
      host.set_lines(1'b1, modes[m] != `RSP_FLOW_RTS);
      apb(`RSP_ADDR_CTRL, 1'b1, ctl(`RSP_KEY_LOCAL, modes[m], `RSP_FMT_8N));
      for (int i = 0; i < HIGH; i++) host.send_char(8'h30 + 8'(i));
      repeat (8) @(posedge pclk);
      check({30'h0, dtr, rts}, (modes[m] == `RSP_FLOW_DTR) ? 32'h1 : 32'h2);
      for (int i = 0; i < HIGH; i++) begin
        apb(`RSP_ADDR_RXD, 1'b0, 32'h0);
        check(rd, {23'h0, 1'b1, 8'h30 + 8'(i)});
      end
      repeat (8) @(posedge pclk);
      check({30'h0, dtr, rts}, 32'h3);
    end
    host.set_lines(1'b1, 1'b1);
    apb(`RSP_ADDR_CTRL, 1'b1, ctl(`RSP_KEY_LOCAL, `RSP_FLOW_XON, `RSP_FMT_8N));
    host.send_char(`RSP_CHAR_XOFF);
    repeat (8) @(posedge pclk);
    apb(`RSP_ADDR_STAT, 1'b0, 32'h0);
    check({31'h0, rd[`RSP_ST_HALT]}, 32'h1);
    c = 8'($urandom);
    apb(`RSP_ADDR_TXD, 1'b1, {24'h0, c});
    repeat (12 * BIT) @(posedge pclk);
    check(32'(host.rx_q.size()), 32'h0);
    host.send_char(`RSP_CHAR_XON);
    get_tx(c);
    host.send_char(`RSP_CHAR_XOFF);
    apb(`RSP_ADDR_TXD, 1'b1, 32'h77);
    host.send_char(`RSP_CHAR_ETX);
    repeat (8) @(posedge pclk);
    apb(`RSP_ADDR_STAT, 1'b0, 32'h0);
    check({30'h0, rd[`RSP_ST_ABORT], rd[`RSP_ST_HALT]}, 32'h2);
    repeat (12 * BIT) @(posedge pclk);
    check(32'(host.rx_q.size()), 32'h0);
    apb(`RSP_ADDR_RXD, 1'b0, 32'h0);
    check({31'h0, rd[8]}, 32'h0);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
